/* File: hw/csbs_defines.vh */
// Constants for the clock source bring-up sequencer.
// Assumes inclusion by bare name from the design files.
`ifndef CSBS_DEFINES_VH
`define CSBS_DEFINES_VH
// Register indices of the clock generator as seen by the sequencer.
`define CSBS_REG_SUB_INIT     8'h00
`define CSBS_REG_SUB_DRIVE    8'h01
`define CSBS_REG_SUB_WAIT     8'h02
`define CSBS_REG_SUB_START    8'h03
`define CSBS_REG_MAIN_DRIVE   8'h04
`define CSBS_REG_MAIN_WAIT    8'h05
`define CSBS_REG_MAIN_START   8'h06
`define CSBS_REG_HSO_POWER    8'h07
`define CSBS_REG_HSO_FREQ     8'h08
`define CSBS_REG_HSO_START    8'h09
`define CSBS_REG_PERIPHERAL_PLL_SRC     8'h0A
`define CSBS_REG_PLL_DIVMUL   8'h0B
`define CSBS_REG_PLL_START    8'h0C
`define CSBS_REG_PERIPHERAL_PLL_DIVMUL  8'h0D
`define CSBS_REG_PERIPHERAL_PLL_START   8'h0E
`define CSBS_REG_PERIPHERAL_PLL_OUTDIV  8'h0F
// Bit positions within osc_stable_flags.
`define CSBS_FLG_SUB          0
`define CSBS_FLG_MAIN         1
`define CSBS_FLG_HSO          2
`define CSBS_FLG_PLL          3
`define CSBS_FLG_PERIPHERAL_PLL         4
// Values written.
`define CSBS_VAL_ONE          8'h01
`define CSBS_VAL_ZERO         8'h00
// Default use selection: main PLL (and main clock) only.
`define CSBS_USE_DEFAULT      6'h12
// Step table depth.
`define CSBS_SEQ_LEN          16
`endif

/* File: hw/csbs_seq_rom.v */
// Step table of the bring-up sequence, one write per entry.
// Assumes a synchronous reader; data appear one clock after the index.
`timescale 1ns/1ns
`include "csbs_defines.vh"
module csbs_seq_rom (
  input  wire       mclk,
  input  wire [3:0] idx,
  output reg  [7:0] reg_q,
  output reg  [2:0] wait_q
);
  // wait_q: 0 none, else flag index plus one to poll after this write.
  always @(posedge mclk) begin
    case (idx)
      4'h0:    begin reg_q <= `CSBS_REG_SUB_INIT;    wait_q <= 3'h0; end
      4'h1:    begin reg_q <= `CSBS_REG_SUB_DRIVE;   wait_q <= 3'h0; end
      4'h2:    begin reg_q <= `CSBS_REG_SUB_WAIT;    wait_q <= 3'h0; end
      4'h3:    begin reg_q <= `CSBS_REG_SUB_START;   wait_q <= 3'h1; end
      4'h4:    begin reg_q <= `CSBS_REG_MAIN_DRIVE;  wait_q <= 3'h0; end
      4'h5:    begin reg_q <= `CSBS_REG_MAIN_WAIT;   wait_q <= 3'h0; end
      4'h6:    begin reg_q <= `CSBS_REG_MAIN_START;  wait_q <= 3'h2; end
      4'h7:    begin reg_q <= `CSBS_REG_HSO_POWER;   wait_q <= 3'h0; end
      4'h8:    begin reg_q <= `CSBS_REG_HSO_FREQ;    wait_q <= 3'h0; end
      4'h9:    begin reg_q <= `CSBS_REG_HSO_START;   wait_q <= 3'h3; end
      4'hA:    begin reg_q <= `CSBS_REG_PERIPHERAL_PLL_SRC;    wait_q <= 3'h0; end
      4'hB:    begin reg_q <= `CSBS_REG_PLL_DIVMUL;  wait_q <= 3'h0; end
      4'hC:    begin reg_q <= `CSBS_REG_PLL_START;   wait_q <= 3'h4; end
      4'hD:    begin reg_q <= `CSBS_REG_PERIPHERAL_PLL_DIVMUL; wait_q <= 3'h0; end
      4'hE:    begin reg_q <= `CSBS_REG_PERIPHERAL_PLL_START;  wait_q <= 3'h5; end
      default: begin reg_q <= `CSBS_REG_PERIPHERAL_PLL_OUTDIV; wait_q <= 3'h0; end
    endcase
  end
endmodule // csbs_seq_rom

/* File: hw/csbs_sequencer.v */
// Clock source bring-up sequencer: walks the clock generator through its start-up writes.
// Assumes the clock generator accepts one write per wr_en pulse and reports
// stable sources on osc_stable_flags, synchronous to mclk.
`timescale 1ns/1ns
`include "csbs_defines.vh"
module csbs_sequencer #(
  parameter [5:0] USE_INIT = `CSBS_USE_DEFAULT
) (
  mclk, rst_n, start, use_sel, sub_drive, main_drive, main_wait, sub_wait,
  hso_freq, peripheral_pll_src, pll_divmul, peripheral_pll_divmul, peripheral_pll_outdiv, osc_stable_flags,
  wr_en, wr_addr, wr_data, busy, done
);
  input  wire       mclk;
  input  wire       rst_n;
  input  wire       start;
  // use_sel bits: 0 sub, 1 main, 2 on-chip osc, 3 peripheral pll, 4 main pll.
  input  wire [5:0] use_sel;
  input  wire [7:0] sub_drive;
  input  wire [7:0] main_drive;
  input  wire [7:0] main_wait;
  input  wire [7:0] sub_wait;
  input  wire [7:0] hso_freq;
  input  wire [7:0] peripheral_pll_src;
  input  wire [7:0] pll_divmul;
  input  wire [7:0] peripheral_pll_divmul;
  input  wire [7:0] peripheral_pll_outdiv;
  input  wire [7:0] osc_stable_flags;
  output reg        wr_en;
  output reg  [7:0] wr_addr;
  output reg  [7:0] wr_data;
  output wire       busy;
  output reg        done;

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  localparam [4:0] S_IDLE  = 5'h01;
  localparam [4:0] S_FETCH = 5'h02;
  localparam [4:0] S_WRITE = 5'h04;
  localparam [4:0] S_POLL  = 5'h08;
  localparam [4:0] S_DONE  = 5'h10;

  reg  [4:0] state_q;
  reg  [4:0] state_d;
  reg  [3:0] idx_q;
  reg  [3:0] idx_d;
  reg  [5:0] use_q;
  wire [7:0] rom_reg;
  wire [2:0] rom_wait;
  wire       flag_hit;

  // ----------------------------------------------------------------
  // Step table
  // ----------------------------------------------------------------
  // The table is a registered lookup, so every entry costs a fetch cycle
  // before its write; this keeps the table decode out of the write path.
  csbs_seq_rom u_rom (
    .mclk   (mclk),
    .idx    (idx_q),
    .reg_q  (rom_reg),
    .wait_q (rom_wait)
  );

  // ----------------------------------------------------------------
  // Entry decoding
  // ----------------------------------------------------------------
  // Decides whether a table entry applies under the chosen use set.
  function entry_on;
    input [3:0] i;
    input [5:0] u;
    begin
      case (i)
        4'h0:    entry_on = 1'b1;
        4'h1, 4'h2, 4'h3: entry_on = u[0];
        4'h4, 4'h5, 4'h6: entry_on = u[1];
        4'h7:    entry_on = ~u[2];
        4'h8, 4'h9: entry_on = u[2];
        4'hA:    entry_on = u[3];
        4'hB, 4'hC: entry_on = u[4];
        4'hD, 4'hE, 4'hF: entry_on = u[3];
        default: entry_on = 1'b0;
      endcase
    end
  endfunction

  // Picks the data byte for the current table entry.
  function [7:0] entry_data;
    input [7:0] r;
    begin
      case (r)
        `CSBS_REG_SUB_DRIVE:   entry_data = sub_drive;
        `CSBS_REG_SUB_WAIT:    entry_data = sub_wait;
        `CSBS_REG_MAIN_DRIVE:  entry_data = main_drive;
        `CSBS_REG_MAIN_WAIT:   entry_data = main_wait;
        `CSBS_REG_HSO_POWER:   entry_data = `CSBS_VAL_ZERO;
        `CSBS_REG_HSO_FREQ:    entry_data = hso_freq;
        `CSBS_REG_PERIPHERAL_PLL_SRC:    entry_data = peripheral_pll_src;
        `CSBS_REG_PLL_DIVMUL:  entry_data = pll_divmul;
        `CSBS_REG_PERIPHERAL_PLL_DIVMUL: entry_data = peripheral_pll_divmul;
        `CSBS_REG_PERIPHERAL_PLL_OUTDIV: entry_data = peripheral_pll_outdiv;
        default:               entry_data = `CSBS_VAL_ONE;
      endcase
    end
  endfunction

  // Picks the stable flag that ends the wait named by a table entry.
  function flag_at;
    input [2:0] w;
    input [7:0] f;
    begin
      case (w)
        3'h1:    flag_at = f[`CSBS_FLG_SUB];
        3'h2:    flag_at = f[`CSBS_FLG_MAIN];
        3'h3:    flag_at = f[`CSBS_FLG_HSO];
        3'h4:    flag_at = f[`CSBS_FLG_PLL];
        3'h5:    flag_at = f[`CSBS_FLG_PERIPHERAL_PLL];
        default: flag_at = 1'b0;
      endcase
    end
  endfunction

  // True for the final table entry, after which the run ends.
  function last_entry;
    input [3:0] i;
    begin
      last_entry = (i == 4'hF);
    end
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // The first poll cycle meets the start write itself, before the clock
  // generator can clear a flag left set by an earlier run; a stale flag
  // would end the wait early, so flags count only once the pulse is gone.
  assign flag_hit = !wr_en && flag_at(rom_wait, osc_stable_flags);

  // Within a run the table index only advances, so the step order is fixed.
  always @* begin
    state_d = state_q;
    idx_d   = idx_q;
    case (state_q)
      S_IDLE: begin
        if (start) begin
          idx_d   = 4'h0;
          state_d = S_FETCH;
        end
      end
      S_FETCH: begin
        // ROM output for idx_q is valid at the next edge.
        state_d = S_WRITE;
      end
      S_WRITE: begin
        if (entry_on(idx_q, use_q) && rom_wait != 3'h0) begin
          state_d = S_POLL;
        end else if (last_entry(idx_q)) begin
          state_d = S_DONE;
        end else begin
          idx_d   = idx_q + 4'h1;
          state_d = S_FETCH;
        end
      end
      S_POLL: begin
        if (flag_hit) begin
          if (last_entry(idx_q)) begin
            state_d = S_DONE;
          end else begin
            idx_d   = idx_q + 4'h1;
            state_d = S_FETCH;
          end
        end
      end
      S_DONE: begin
        if (start) begin
          idx_d   = 4'h0;
          state_d = S_FETCH;
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      idx_q   <= 4'h0;
      use_q   <= USE_INIT;
      wr_en   <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
      done    <= 1'b0;
    end else begin
      state_q <= state_d;
      idx_q   <= idx_d;
      // Use selection is frozen for a whole run so steps stay consistent.
      if ((state_q == S_IDLE || state_q == S_DONE) && start) begin
        use_q <= use_sel;
        done  <= 1'b0;
      end else if (state_d == S_DONE) begin
        done  <= 1'b1;
      end
      wr_en <= (state_q == S_WRITE) && entry_on(idx_q, use_q);
      if (state_q == S_WRITE && entry_on(idx_q, use_q)) begin
        wr_addr <= rom_reg;
        wr_data <= entry_data(rom_reg);
      end
    end
  end

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  // Busy is decoded from the state register alone, so it needs no reset term.
  assign busy = (state_q != S_IDLE) && (state_q != S_DONE);
endmodule // csbs_sequencer

/* File: test/csbs_sequencer_assertions.sv */
// Checker for the write stream of the clock source bring-up sequencer.
// Assumes use_sel is held steady while a run is in progress.
`timescale 1ns/1ns
module csbs_chk (
  input wire       mclk,
  input wire       rst_n,
  input wire       start,
  input wire [5:0] use_sel,
  input wire [7:0] osc_stable_flags,
  input wire       wr_en,
  input wire [7:0] wr_addr,
  input wire [7:0] wr_data,
  input wire       busy,
  input wire       done
);
  reg       seen_q;
  reg [7:0] last_q;
  always @(posedge mclk) begin
    if (!rst_n || (start && !busy)) seen_q <= 1'b0;
    else if (wr_en) seen_q <= 1'b1;
    if (wr_en) last_q <= wr_addr;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_ORDER: assert property (wr_en && seen_q |-> wr_addr > last_q)
    else $error("write out of order");
  AST_GAP: assert property (wr_en |=> !wr_en)
    else $error("writes back to back");
  AST_FIRST: assert property (start && !busy |-> ##3 wr_en && wr_addr == 8'h00)
    else $error("sub-clock init not first");
  AST_SUB: assert property (wr_en && wr_addr > 8'h00 && wr_addr < 8'h04 |-> use_sel[0])
    else $error("sub-clock write while unused");
  AST_MAIN: assert property (wr_en && wr_addr > 8'h03 && wr_addr < 8'h07 |-> use_sel[1])
    else $error("main osc write while unused");
  AST_HSO_OFF: assert property (
    wr_en && wr_addr == 8'h07 |-> !use_sel[2] && wr_data == 8'h00)
    else $error("bad on-chip osc power-off");
  AST_HSO_ON: assert property (
    wr_en && wr_addr == 8'h09 |-> use_sel[2] && wr_data == 8'h01)
    else $error("bad on-chip osc start");
  AST_SRC: assert property (wr_en && wr_addr == 8'h0A |-> use_sel[3])
    else $error("source select while unused");
  AST_PLL_WAIT: assert property (
    wr_en && wr_addr == 8'h0C ##1 !osc_stable_flags[3] |=> (!wr_en) [*3])
    else $error("write during PLL wait");
  AST_OUTDIV: assert property (
    wr_en && wr_addr == 8'h0F |-> osc_stable_flags[4] && use_sel[3])
    else $error("output divider before stable");
  AST_DONE: assert property ($fell(busy) |-> done)
    else $error("busy dropped without done");
endmodule // csbs_chk
bind csbs_sequencer csbs_chk i_chk (.mclk(mclk), .rst_n(rst_n), .start(start), .use_sel(use_sel),
  .osc_stable_flags(osc_stable_flags), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
  .busy(busy), .done(done));

/* File: test/csbs_dev_model.sv */
// Behavioural clock generator: a start write clears a flag, which rises dly cycles later.
// Assumes one write per wr_en cycle; dly of one or more.
`timescale 1ns/1ns
module csbs_dev_model (
  input  wire       mclk,
  input  wire       rst_n,
  input  wire [3:0] dly,
  input  wire       wr_en,
  input  wire [7:0] wr_addr,
  input  wire [7:0] wr_data,
  output reg  [7:0] osc_stable_flags
);
  localparam [15:0] STARTS = 16'h5248;
  reg [3:0] cnt_q;
  reg [2:0] bit_q;
  wire [7:0] quot;
  wire [2:0] start_bit;
  assign quot      = wr_addr / 8'h03;
  // The peripheral PLL start breaks the every-third-register pattern.
  assign start_bit = (wr_addr == 8'h0E) ? 3'h4 : quot[2:0] - 3'h1;
  always @(posedge mclk) begin
    if (!rst_n) begin
      osc_stable_flags <= 8'h00;
      cnt_q            <= 4'h0;
    end else if (wr_en && STARTS[wr_addr[3:0]] && wr_data == 8'h01) begin
      bit_q                       <= start_bit;
      osc_stable_flags[start_bit] <= 1'b0;
      cnt_q                       <= dly;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
      if (cnt_q == 4'h1) osc_stable_flags[bit_q] <= 1'b1;
    end
  end
endmodule // csbs_dev_model

/* File: test/test_clock_source_bringup_sequencer.sv */
// Self-checking bench for the bring-up sequencer with a behavioural clock generator.
// Assumes the checker is bound to the sequencer.
`timescale 1ns/1ns
`define chk(n, e, a) begin comparisons = comparisons + 1; if ((a) !== (e)) begin \
  mismatches = mismatches + 1; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module test_clock_source_bringup_sequencer;
  reg         mclk = 1'b0;
  reg         rst_n = 1'b0;
  reg         start = 1'b0;
  reg  [5:0]  use_sel = 6'h00;
  reg  [3:0]  dly = 4'h1;
  wire        wr_en, busy, done;
  wire [7:0]  wr_addr, wr_data, flags;
  integer     mismatches = 0;
  integer     comparisons = 0;
  integer     wcount, i;
  reg  [15:0] seen_map;
  reg  [7:0]  exp_data;
  reg  [25:0] rows [0:4];
  csbs_sequencer i_dut (.mclk(mclk), .rst_n(rst_n), .start(start), .use_sel(use_sel),
    .sub_drive({~dly, 4'h1}), .main_drive({~dly, 4'h4}), .main_wait({~dly, 4'h5}),
    .sub_wait({~dly, 4'h2}), .hso_freq({~dly, 4'h8}), .peripheral_pll_src({~dly, 4'hA}),
    .pll_divmul({~dly, 4'hB}), .peripheral_pll_divmul({~dly, 4'hD}), .peripheral_pll_outdiv({~dly, 4'hF}),
    .osc_stable_flags(flags), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .busy(busy), .done(done));
  csbs_dev_model i_dev (.mclk(mclk), .rst_n(rst_n), .dly(dly), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .osc_stable_flags(flags));
  always #5 mclk = ~mclk;
  // Writes are logged on the falling edge, where the registered pulse has settled.
  always @(negedge mclk) begin
    if (wr_en) begin
      seen_map = seen_map | (16'h0001 << wr_addr[3:0]);
      wcount = wcount + 1;
      // Start writes and the sub-clock init carry one, the power-off carries zero.
      if (wr_addr == 8'h00 || ((16'h5248 >> wr_addr[3:0]) & 16'h0001) != 16'h0000)
        exp_data = 8'h01;
      else if (wr_addr == 8'h07)
        exp_data = 8'h00;
      else
        exp_data = {~dly, wr_addr[3:0]};
      `chk("wr_data", exp_data, wr_data)
    end
  end
  task final_report;
    begin
      if (mismatches == 0 && comparisons > 0) begin
        $display("DONE - PASS");
      end else begin
        $display("DONE - FAIL");
      end
      $finish;
    end
  endtask
  task run(input [25:0] r, input dup);
    integer k;
    begin
      @(negedge mclk);
      {use_sel, dly} = r[25:16];
      seen_map = 16'h0000;
      wcount = 0;
      start = 1'b1;
      @(negedge mclk);
      start = 1'b0;
      `chk("busy", 1'b1, busy)
      repeat (5) @(negedge mclk);
      start = dup;
      @(negedge mclk);
      start = 1'b0;
      for (k = 0; k < 400 && done !== 1'b1; k++) @(negedge mclk);
      // The last write can pulse together with done; let the monitor log it.
      @(negedge mclk);
      `chk("done", 1'b1, done)
      `chk("map", r[15:0], seen_map)
      `chk("count", $countones(r[15:0]), wcount)
    end
  endtask
  initial begin
    #100000;
    mismatches = mismatches + 1;
    final_report;
  end
  initial begin
    rows[0] = {6'h12, 4'h1, 16'h18F1};
    rows[1] = {6'h00, 4'h3, 16'h0081};
    rows[2] = {6'h1F, 4'h9, 16'hFF7F};
    rows[3] = {6'h0D, 4'h2, 16'hE70F};
    rows[4] = {6'h16, 4'h4, 16'h1B71};
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    `chk("reset", 19'h00000, {wr_en, wr_addr, wr_data, busy, done})
    for (i = 0; i < 5; i++) run(rows[i], 1'b0);
    // A second start in mid-run must not restart or repeat any write.
    run(rows[0], 1'b1);
    use_sel = 6'h1F;
    start = 1'b1;
    @(negedge mclk);
    start = 1'b0;
    repeat (8) @(negedge mclk);
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    `chk("mid reset", 19'h00000, {wr_en, wr_addr, wr_data, busy, done})
    rst_n = 1'b1;
    run(rows[3], 1'b0);
    final_report;
  end
endmodule // test_clock_source_bringup_sequencer
